// *** hdl/cps_defs.vh ***
// constants for the cycling preset sequencer
`ifndef CPS_DEFS_VH
`define CPS_DEFS_VH

// register offsets
`define CPS_A_CTRL        8'h00
`define CPS_A_FEAT_SEL    8'h01
`define CPS_A_FEAT_EN     8'h02
`define CPS_A_EDIT_SEL    8'h03
`define CPS_A_COUNT       8'h04
`define CPS_A_GLOBAL_CNT  8'h05
`define CPS_A_EVENT       8'h06
`define CPS_A_STATUS      8'h07
`define CPS_A_GAIN_SEL    8'h08
`define CPS_A_COLOR_SEL   8'h09
`define CPS_A_PIN_SEL     8'h0a
`define CPS_A_STD_WRITE   8'h0b
`define CPS_A_MAX_EXP     8'h0c
`define CPS_A_P_REPEAT    8'h10
`define CPS_A_P_EXPTIME   8'h11
`define CPS_A_P_EXPDELAY  8'h12
`define CPS_A_P_GAIN      8'h13
`define CPS_A_P_COLOR     8'h14
`define CPS_A_P_LEFT      8'h15
`define CPS_A_P_TOP       8'h16
`define CPS_A_P_HMERGE    8'h17
`define CPS_A_P_VMERGE    8'h18
`define CPS_A_P_PIN       8'h19

// cyclable feature codes
`define CPS_F_EXPTIME     4'h0
`define CPS_F_EXPDELAY    4'h1
`define CPS_F_ROI         4'h2
`define CPS_F_PIN_A       4'h3
`define CPS_F_PIN_B       4'h4
`define CPS_F_PIN_C       4'h5
`define CPS_F_HMERGE      4'h6
`define CPS_F_VMERGE      4'h7
`define CPS_F_GAIN        4'h8
`define CPS_F_COLOR       4'h9
`define CPS_F_REPEAT      4'ha
`define CPS_NFEAT         11

// control and event bits
`define CPS_B_RUN         0
`define CPS_B_SYNC_INC    1
`define CPS_B_AUTO_WB     2
`define CPS_B_AUTO_BRIGHT 3
`define CPS_B_ADVANCE     0
`define CPS_B_RESTART     1

// gain target and colour codes
`define CPS_GT_WHOLE      2'h0
`define CPS_COL_RED       2'h0
`define CPS_COL_GREEN     2'h1
`define CPS_COL_BLUE      2'h2

// reset values
`define CPS_RST_COUNT     4'h1
`define CPS_RST_GLOBAL    16'h0001
`define CPS_RST_REPEAT    16'h0001
`define CPS_RST_MERGE     4'h1
`define CPS_RST_GAIN      16'h0000

`endif

// *** hdl/cps_max_exposure.v ***
// registered maximum of the exposure times of the first count_in presets, recomputed every cycle
`timescale 1ns/100ps

module cps_max_exposure #(
	parameter NPRESET = 4,
	parameter IW      = 2,
	parameter DW      = 24
) (
	input  wire                clock_in,
	input  wire                rst_in,
	input  wire [NPRESET*DW-1:0] exp_flat_in,
	input  wire [IW:0]         count_in,
	output reg  [DW-1:0]       max_exp_out
);

	reg [DW-1:0] max_nxt;
	integer      i;

	always @* begin
		max_nxt = {DW{1'b0}};
		for (i = 0; i < NPRESET; i = i + 1) begin
			if (i < count_in && exp_flat_in[i*DW +: DW] > max_nxt) begin
				max_nxt = exp_flat_in[i*DW +: DW];
			end
		end
	end

	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			max_exp_out <= {DW{1'b0}};
		end else begin
			max_exp_out <= max_nxt;
		end
	end

endmodule

// *** hdl/cps_sequencer.v ***
// cycling preset sequencer: preset storage, index stepping and parameter outputs
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "cps_defs.vh"

module cps_sequencer #(
	parameter NPRESET = 4,
	parameter IW      = 2,
	parameter TW      = 24,
	parameter GW      = 16,
	parameter OW      = 16
) (
	input  wire          clock_in,
	input  wire          rst_in,
	input  wire [7:0]    addr_in,
	input  wire [31:0]   wdata_in,
	input  wire          wr_in,
	input  wire          rd_in,
	output reg  [31:0]   rdata_out,
	output reg  [IW-1:0] active_index_out,
	output reg  [TW-1:0] exposure_time_out,
	output reg  [TW-1:0] exposure_delay_out,
	output reg  [GW-1:0] analog_gain_out,
	output reg  [GW-1:0] digital_gain_out,
	output reg  [GW-1:0] red_gain_out,
	output reg  [GW-1:0] green_gain_out,
	output reg  [GW-1:0] blue_gain_out,
	output reg  [OW-1:0] roi_left_offset_out,
	output reg  [OW-1:0] roi_top_offset_out,
	output reg  [3:0]    horiz_cell_merge_out,
	output reg  [3:0]    vert_cell_merge_out,
	output reg  [2:0]    output_pin_ctrl_out,
	output reg  [2:0]    output_pin_cycled_out,
	output reg  [`CPS_NFEAT-1:0] std_read_only_out,
	output reg  [TW-1:0] max_exposure_out
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN  = 2'b10;
	localparam [3:0] COUNT_RST = `CPS_RST_COUNT;

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	reg [1:0]            state_r;
	reg [3:0]            ctrl_r;
	reg [3:0]            feat_sel_r;
	reg [`CPS_NFEAT-1:0] feat_en_r;
	reg [IW-1:0]         edit_sel_r;
	reg [IW:0]           count_r;
	reg [15:0]           global_cnt_r;
	reg [1:0]            gain_sel_r;
	reg [1:0]            color_sel_r;
	reg [1:0]            pin_sel_r;
	reg [15:0]           event_cnt_r;
	reg                  restart_pend_r;
	reg                  std_reject_r;

	// ------------------------------------------------------------
	// preset storage
	// ------------------------------------------------------------
	reg [15:0]   p_repeat_r   [0:NPRESET-1];
	reg [TW-1:0] p_exptime_r  [0:NPRESET-1];
	reg [TW-1:0] p_expdelay_r [0:NPRESET-1];
	reg [GW-1:0] p_gain_r     [0:NPRESET-1];
	reg [GW-1:0] p_red_r      [0:NPRESET-1];
	reg [GW-1:0] p_green_r    [0:NPRESET-1];
	reg [GW-1:0] p_blue_r     [0:NPRESET-1];
	reg [OW-1:0] p_left_r     [0:NPRESET-1];
	reg [OW-1:0] p_top_r      [0:NPRESET-1];
	reg [3:0]    p_hmerge_r   [0:NPRESET-1];
	reg [3:0]    p_vmerge_r   [0:NPRESET-1];
	reg [2:0]    p_pin_r      [0:NPRESET-1];

	wire [NPRESET*TW-1:0] exp_flat;
	wire [TW-1:0]         max_exp;

	function is_write;
		input [7:0] a;
		input [7:0] target;
		begin
			is_write = wr_in && (a == target);
		end
	endfunction

	function [GW-1:0] pick_color;
		input [1:0]    sel;
		input [GW-1:0] r;
		input [GW-1:0] g;
		input [GW-1:0] b;
		begin
			case (sel)
				`CPS_COL_RED:   pick_color = r;
				`CPS_COL_GREEN: pick_color = g;
				default:        pick_color = b;
			endcase
		end
	endfunction

	wire ev_advance = is_write(addr_in, `CPS_A_EVENT) && wdata_in[`CPS_B_ADVANCE];
	wire ev_restart = is_write(addr_in, `CPS_A_EVENT) && wdata_in[`CPS_B_RESTART];
	wire running    = state_r == ST_RUN;
	wire color_ok   = !ctrl_r[`CPS_B_AUTO_WB] && !ctrl_r[`CPS_B_AUTO_BRIGHT];
	wire [15:0] cur_repeat = feat_en_r[`CPS_F_REPEAT] ? p_repeat_r[active_index_out]
		: global_cnt_r;
	wire [IW-1:0] last_index = count_r[IW-1:0] - {{(IW-1){1'b0}}, 1'b1};
	wire sync_inc    = ctrl_r[`CPS_B_SYNC_INC];
	wire do_restart  = sync_inc ? (ev_advance && (ev_restart || restart_pend_r))
		: ev_restart;

	// ------------------------------------------------------------
	// control, selectors and index stepping
	// ------------------------------------------------------------
	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_r          <= ST_IDLE;
			ctrl_r           <= 4'h0;
			feat_sel_r       <= 4'h0;
			feat_en_r        <= {`CPS_NFEAT{1'b0}};
			edit_sel_r       <= {IW{1'b0}};
			count_r          <= COUNT_RST[IW:0];
			global_cnt_r     <= `CPS_RST_GLOBAL;
			gain_sel_r       <= `CPS_GT_WHOLE;
			color_sel_r      <= `CPS_COL_RED;
			pin_sel_r        <= 2'h0;
			event_cnt_r      <= 16'h0000;
			restart_pend_r   <= 1'b0;
			std_reject_r     <= 1'b0;
			active_index_out <= {IW{1'b0}};
		end else begin
			if (is_write(addr_in, `CPS_A_CTRL))      ctrl_r <= wdata_in[3:0];
			if (is_write(addr_in, `CPS_A_FEAT_SEL))  feat_sel_r <= wdata_in[3:0];
			if (is_write(addr_in, `CPS_A_FEAT_EN) && feat_sel_r < `CPS_NFEAT)
				feat_en_r[feat_sel_r] <= wdata_in[0];
			if (is_write(addr_in, `CPS_A_EDIT_SEL))  edit_sel_r <= wdata_in[IW-1:0];
			if (is_write(addr_in, `CPS_A_COUNT) && wdata_in[IW:0] != 0
				&& wdata_in[IW:0] <= NPRESET)
				count_r <= wdata_in[IW:0];
			if (is_write(addr_in, `CPS_A_GLOBAL_CNT)) global_cnt_r <= wdata_in[15:0];
			if (is_write(addr_in, `CPS_A_GAIN_SEL))  gain_sel_r <= wdata_in[1:0];
			if (is_write(addr_in, `CPS_A_COLOR_SEL) && wdata_in[1:0] != 2'h3)
				color_sel_r <= wdata_in[1:0];
			if (is_write(addr_in, `CPS_A_PIN_SEL) && wdata_in[1:0] != 2'h3)
				pin_sel_r <= wdata_in[1:0];
			// standard-control write attempt on a cycled feature is refused
			if (is_write(addr_in, `CPS_A_STD_WRITE) && wdata_in[3:0] < `CPS_NFEAT)
				std_reject_r <= feat_en_r[wdata_in[3:0]];
			case (state_r)
				ST_IDLE: begin
					if (ctrl_r[`CPS_B_RUN]) state_r <= ST_RUN;
				end
				ST_RUN: begin
					if (!ctrl_r[`CPS_B_RUN]) state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
			// a restart written with an advance in the same cycle wins and clears the pending flag
			if (sync_inc && ev_restart && !ev_advance)
				restart_pend_r <= 1'b1;
			else if (do_restart)
				restart_pend_r <= 1'b0;
			if (do_restart) begin
				active_index_out <= {IW{1'b0}};
				event_cnt_r      <= 16'h0000;
			end else if (running && ev_advance) begin
				if (event_cnt_r + 16'h0001 >= cur_repeat) begin
					event_cnt_r <= 16'h0000;
					if (active_index_out >= last_index)
						active_index_out <= {IW{1'b0}};
					else
						active_index_out <= active_index_out + {{(IW-1){1'b0}}, 1'b1};
				end else begin
					event_cnt_r <= event_cnt_r + 16'h0001;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// per-preset storage writes through the edit selector
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NPRESET; g = g + 1) begin : preset
			wire sel = edit_sel_r == g;
			assign exp_flat[g*TW +: TW] = p_exptime_r[g];
			always @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					p_repeat_r[g]   <= `CPS_RST_REPEAT;
					p_exptime_r[g]  <= {TW{1'b0}};
					p_expdelay_r[g] <= {TW{1'b0}};
					p_gain_r[g]     <= {GW{1'b0}};
					p_red_r[g]      <= {GW{1'b0}};
					p_green_r[g]    <= {GW{1'b0}};
					p_blue_r[g]     <= {GW{1'b0}};
					p_left_r[g]     <= {OW{1'b0}};
					p_top_r[g]      <= {OW{1'b0}};
					p_hmerge_r[g]   <= `CPS_RST_MERGE;
					p_vmerge_r[g]   <= `CPS_RST_MERGE;
					p_pin_r[g]      <= 3'h0;
				end else if (sel) begin
					if (is_write(addr_in, `CPS_A_P_REPEAT))   p_repeat_r[g] <= wdata_in[15:0];
					if (is_write(addr_in, `CPS_A_P_EXPTIME))  p_exptime_r[g] <= wdata_in[TW-1:0];
					if (is_write(addr_in, `CPS_A_P_EXPDELAY)) p_expdelay_r[g] <= wdata_in[TW-1:0];
					if (is_write(addr_in, `CPS_A_P_GAIN))     p_gain_r[g] <= wdata_in[GW-1:0];
					if (is_write(addr_in, `CPS_A_P_COLOR) && color_ok) begin
						if (color_sel_r == `CPS_COL_RED)   p_red_r[g] <= wdata_in[GW-1:0];
						if (color_sel_r == `CPS_COL_GREEN) p_green_r[g] <= wdata_in[GW-1:0];
						if (color_sel_r == `CPS_COL_BLUE)  p_blue_r[g] <= wdata_in[GW-1:0];
					end
					if (is_write(addr_in, `CPS_A_P_LEFT))     p_left_r[g] <= wdata_in[OW-1:0];
					if (is_write(addr_in, `CPS_A_P_TOP))      p_top_r[g] <= wdata_in[OW-1:0];
					if (is_write(addr_in, `CPS_A_P_HMERGE) && wdata_in[3:0] != 4'h0)
						p_hmerge_r[g] <= wdata_in[3:0];
					if (is_write(addr_in, `CPS_A_P_VMERGE) && wdata_in[3:0] != 4'h0)
						p_vmerge_r[g] <= wdata_in[3:0];
					if (is_write(addr_in, `CPS_A_P_PIN))
						p_pin_r[g][pin_sel_r] <= wdata_in[0];
				end
			end
		end
	endgenerate

	cps_max_exposure #(
		.NPRESET (NPRESET),
		.IW      (IW),
		.DW      (TW)
	) u_max (
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.exp_flat_in (exp_flat),
		.count_in    (count_r),
		.max_exp_out (max_exp)
	);

	// ------------------------------------------------------------
	// parameters of the active preset
	// ------------------------------------------------------------
	wire [IW-1:0] ai = active_index_out;
	wire [GW-1:0] half = {1'b1, {(GW-1){1'b0}}};
	wire [GW-1:0] act_gain = p_gain_r[ai];

	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			exposure_time_out     <= {TW{1'b0}};
			exposure_delay_out    <= {TW{1'b0}};
			analog_gain_out       <= {GW{1'b0}};
			digital_gain_out      <= {GW{1'b0}};
			red_gain_out          <= {GW{1'b0}};
			green_gain_out        <= {GW{1'b0}};
			blue_gain_out         <= {GW{1'b0}};
			roi_left_offset_out   <= {OW{1'b0}};
			roi_top_offset_out    <= {OW{1'b0}};
			horiz_cell_merge_out  <= `CPS_RST_MERGE;
			vert_cell_merge_out   <= `CPS_RST_MERGE;
			output_pin_ctrl_out   <= 3'h0;
			output_pin_cycled_out <= 3'h0;
			std_read_only_out     <= {`CPS_NFEAT{1'b0}};
			max_exposure_out      <= {TW{1'b0}};
		end else begin
			std_read_only_out  <= feat_en_r;
			max_exposure_out   <= feat_en_r[`CPS_F_EXPTIME] ? max_exp : {TW{1'b0}};
			exposure_time_out  <= p_exptime_r[ai];
			exposure_delay_out <= p_expdelay_r[ai];
			if (gain_sel_r == `CPS_GT_WHOLE) begin
				analog_gain_out  <= act_gain < half ? act_gain : half;
				digital_gain_out <= act_gain < half ? {GW{1'b0}} : act_gain - half;
			end else begin
				analog_gain_out  <= act_gain;
				digital_gain_out <= {GW{1'b0}};
			end
			red_gain_out   <= color_ok ? p_red_r[ai] : {GW{1'b0}};
			green_gain_out <= color_ok ? p_green_r[ai] : {GW{1'b0}};
			blue_gain_out  <= color_ok ? p_blue_r[ai] : {GW{1'b0}};
			roi_left_offset_out  <= p_left_r[ai];
			roi_top_offset_out   <= p_top_r[ai];
			horiz_cell_merge_out <= p_hmerge_r[ai];
			vert_cell_merge_out  <= p_vmerge_r[ai];
			output_pin_ctrl_out  <= p_pin_r[ai];
			output_pin_cycled_out <= feat_en_r[`CPS_F_PIN_C:`CPS_F_PIN_A];
		end
	end

	// ------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ------------------------------------------------------------
	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 32'h00000000;
		end else if (rd_in) begin
			case (addr_in)
				`CPS_A_CTRL:       rdata_out <= {28'h0000000, ctrl_r};
				`CPS_A_FEAT_SEL:   rdata_out <= {28'h0000000, feat_sel_r};
				`CPS_A_FEAT_EN:    rdata_out <= {31'h00000000,
					feat_sel_r < `CPS_NFEAT ? feat_en_r[feat_sel_r] : 1'b0};
				`CPS_A_EDIT_SEL:   rdata_out <= {{(32-IW){1'b0}}, edit_sel_r};
				`CPS_A_COUNT:      rdata_out <= {{(31-IW){1'b0}}, count_r};
				`CPS_A_GLOBAL_CNT: rdata_out <= {16'h0000, global_cnt_r};
				`CPS_A_STATUS:     rdata_out <= {event_cnt_r, 8'h00, running, std_reject_r,
					restart_pend_r, color_ok, 4'h0} | {{(32-IW){1'b0}}, active_index_out};
				`CPS_A_GAIN_SEL:   rdata_out <= {30'h00000000, gain_sel_r};
				`CPS_A_COLOR_SEL:  rdata_out <= {30'h00000000, color_sel_r};
				`CPS_A_PIN_SEL:    rdata_out <= {30'h00000000, pin_sel_r};
				`CPS_A_MAX_EXP:    rdata_out <= {{(32-TW){1'b0}}, max_exp};
				`CPS_A_P_REPEAT:   rdata_out <= {16'h0000, p_repeat_r[edit_sel_r]};
				`CPS_A_P_EXPTIME:  rdata_out <= {{(32-TW){1'b0}}, p_exptime_r[edit_sel_r]};
				`CPS_A_P_EXPDELAY: rdata_out <= {{(32-TW){1'b0}}, p_expdelay_r[edit_sel_r]};
				`CPS_A_P_GAIN:     rdata_out <= {{(32-GW){1'b0}}, p_gain_r[edit_sel_r]};
				`CPS_A_P_COLOR:    rdata_out <= {{(32-GW){1'b0}}, pick_color(color_sel_r,
					p_red_r[edit_sel_r], p_green_r[edit_sel_r], p_blue_r[edit_sel_r])};
				`CPS_A_P_LEFT:     rdata_out <= {{(32-OW){1'b0}}, p_left_r[edit_sel_r]};
				`CPS_A_P_TOP:      rdata_out <= {{(32-OW){1'b0}}, p_top_r[edit_sel_r]};
				`CPS_A_P_HMERGE:   rdata_out <= {28'h0000000, p_hmerge_r[edit_sel_r]};
				`CPS_A_P_VMERGE:   rdata_out <= {28'h0000000, p_vmerge_r[edit_sel_r]};
				`CPS_A_P_PIN:      rdata_out <= {31'h00000000, p_pin_r[edit_sel_r][pin_sel_r]};
				default:           rdata_out <= 32'h00000000;
			endcase
		end
	end

endmodule

// *** test/cps_sequencer_props.sv ***
// property checker for the cycling preset sequencer
`timescale 1ns/100ps
`include "cps_defs.vh"

module cps_sequencer_props #(
	parameter NPRESET = 4,
	parameter IW      = 2,
	parameter TW      = 24,
	parameter GW      = 16
) (
	input wire          clock_in,
	input wire          rst_in,
	input wire [7:0]    addr_in,
	input wire [31:0]   wdata_in,
	input wire          wr_in,
	input wire [IW-1:0] active_index_out,
	input wire [GW-1:0] analog_gain_out,
	input wire [GW-1:0] digital_gain_out,
	input wire [GW-1:0] red_gain_out,
	input wire [GW-1:0] green_gain_out,
	input wire [GW-1:0] blue_gain_out,
	input wire [3:0]    horiz_cell_merge_out,
	input wire [3:0]    vert_cell_merge_out,
	input wire [`CPS_NFEAT-1:0] std_read_only_out,
	input wire [TW-1:0] max_exposure_out
);
	// ----------------------------------------
	// shadow of the selector and control
	// ----------------------------------------
	reg  [7:0] feat_sel_r;
	reg  [3:0] ctrl_r;
	wire       ev_wr = wr_in && addr_in == `CPS_A_EVENT;

	always @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			feat_sel_r <= 8'h00;
			ctrl_r     <= 4'h0;
		end else if (wr_in) begin
			if (addr_in == `CPS_A_FEAT_SEL)
				feat_sel_r <= wdata_in[7:0];
			if (addr_in == `CPS_A_CTRL)
				ctrl_r <= wdata_in[3:0];
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);

	a_enable_sets_readonly: assert property (
		wr_in && addr_in == `CPS_A_FEAT_EN && feat_sel_r < 8'h0b |->
		##2 std_read_only_out[$past(feat_sel_r, 2)] == $past(wdata_in[0], 2))
		else $error("read-only flag does not follow enable");
	a_merge_nonzero: assert property (
		horiz_cell_merge_out != 4'h0 && vert_cell_merge_out != 4'h0)
		else $error("merge factor is zero");
	a_gain_split_half: assert property (
		digital_gain_out != 0 |-> analog_gain_out == {1'b1, {(GW-1){1'b0}}})
		else $error("digital gain used below analog half");
	a_async_restart: assert property (
		ev_wr && wdata_in[1] && !ctrl_r[1] |=> active_index_out == 0)
		else $error("restart did not return to first preset");
	a_sync_restart_waits: assert property (
		ev_wr && wdata_in == 32'h2 && ctrl_r[1] |=> $stable(active_index_out))
		else $error("pended restart acted early");
	a_index_on_event: assert property (
		$changed(active_index_out) |-> $past(ev_wr))
		else $error("index moved without an event");
	a_index_step_one: assert property (
		$changed(active_index_out) && active_index_out != 0 |->
		active_index_out - $past(active_index_out) == 1)
		else $error("index skipped a preset");
	a_colour_auto_off: assert property (
		wr_in && addr_in == `CPS_A_CTRL && (wdata_in[2] || wdata_in[3]) |->
		##3 (red_gain_out == 0 && green_gain_out == 0 && blue_gain_out == 0))
		else $error("colour gains live under auto control");
	a_max_exp_idle: assert property (
		!std_read_only_out[0] [*4] |-> max_exposure_out == 0)
		else $error("max exposure without exposure cycling");

	c_advance: cover property (ev_wr ##1 $changed(active_index_out));
	c_digital: cover property (digital_gain_out != 0);
	c_sync_restart: cover property (ev_wr && wdata_in[1] && ctrl_r[1]);
endmodule

bind cps_sequencer cps_sequencer_props #(.NPRESET(NPRESET), .IW(IW), .TW(TW), .GW(GW))
	cps_sequencer_props_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .active_index_out(active_index_out),
	.analog_gain_out(analog_gain_out), .digital_gain_out(digital_gain_out),
	.red_gain_out(red_gain_out), .green_gain_out(green_gain_out),
	.blue_gain_out(blue_gain_out), .horiz_cell_merge_out(horiz_cell_merge_out),
	.vert_cell_merge_out(vert_cell_merge_out), .std_read_only_out(std_read_only_out),
	.max_exposure_out(max_exposure_out));

// *** test/tb.sv ***
// self-checking bench for the cycling preset sequencer
`timescale 1ns/100ps
`include "cps_defs.vh"

module tb;
	reg         clock_in;
	reg         rst_in;
	reg  [7:0]  addr_in;
	reg  [31:0] wdata_in;
	reg         wr_in;
	reg         rd_in;
	wire [31:0] rdata_out;
	wire [1:0]  active_index_out;
	wire [23:0] exposure_time_out;
	wire [23:0] exposure_delay_out;
	wire [15:0] analog_gain_out;
	wire [15:0] digital_gain_out;
	wire [15:0] red_gain_out;
	wire [15:0] green_gain_out;
	wire [15:0] blue_gain_out;
	wire [15:0] roi_left_offset_out;
	wire [15:0] roi_top_offset_out;
	wire [3:0]  horiz_cell_merge_out;
	wire [3:0]  vert_cell_merge_out;
	wire [2:0]  output_pin_ctrl_out;
	wire [2:0]  output_pin_cycled_out;
	wire [10:0] std_read_only_out;
	wire [23:0] max_exposure_out;
	integer     error_cnt;
	integer     total_checks;
	integer     cyc;
	integer     k;
	integer     idx;
	integer     cnt;
	reg  [31:0] got;
	reg  [23:0] expt [0:2];
	reg  [15:0] gn [0:2];
	reg  [1:0]  rep [0:2];

	cps_sequencer cps_sequencer_inst (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.active_index_out(active_index_out), .exposure_time_out(exposure_time_out),
		.exposure_delay_out(exposure_delay_out), .analog_gain_out(analog_gain_out),
		.digital_gain_out(digital_gain_out), .red_gain_out(red_gain_out),
		.green_gain_out(green_gain_out), .blue_gain_out(blue_gain_out),
		.roi_left_offset_out(roi_left_offset_out), .roi_top_offset_out(roi_top_offset_out),
		.horiz_cell_merge_out(horiz_cell_merge_out), .vert_cell_merge_out(vert_cell_merge_out),
		.output_pin_ctrl_out(output_pin_ctrl_out),
		.output_pin_cycled_out(output_pin_cycled_out),
		.std_read_only_out(std_read_only_out), .max_exposure_out(max_exposure_out));

	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task end_sim;
		begin
			if (error_cnt == 0 && total_checks > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask

	task chk(input [31:0] g, input [31:0] e);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("ERROR %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	task idle(input integer n);
		begin
			repeat (n) @(posedge clock_in);
			#1;
		end
	endtask

	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clock_in);
			addr_in  <= a;
			wdata_in <= d;
			wr_in    <= 1'b1;
			@(posedge clock_in);
			wr_in <= 1'b0;
		end
	endtask

	task rd(input [7:0] a);
		begin
			@(posedge clock_in);
			addr_in <= a;
			rd_in   <= 1'b1;
			@(posedge clock_in);
			rd_in <= 1'b0;
			#1;
			got = rdata_out;
		end
	endtask

	task adv;
		begin
			wr(`CPS_A_EVENT, 32'h1);
			idle(3);
			cnt = cnt + 1;
			if (cnt >= rep[idx]) begin
				cnt = 0;
				idx = (idx + 1) % 3;
			end
		end
	endtask

	task chk_set;
		begin
			chk(active_index_out, idx);
			chk(exposure_time_out, expt[idx]);
			chk(exposure_delay_out, expt[idx] + 5);
			chk(analog_gain_out, gn[idx] > 16'h8000 ? 16'h8000 : gn[idx]);
			chk(digital_gain_out, gn[idx] > 16'h8000 ? gn[idx] - 16'h8000 : 16'h0);
			chk(roi_left_offset_out, idx * 16 + 3);
			chk(roi_top_offset_out, idx * 8 + 1);
			chk(horiz_cell_merge_out, idx + 1);
			chk(vert_cell_merge_out, idx + 2);
		end
	endtask

	// ----------------------------------------
	// clock, timeout and test sequence
	// ----------------------------------------
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end

	always @(posedge clock_in) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			error_cnt = error_cnt + 1;
			end_sim;
		end
	end

	initial begin
		rst_in = 1'b1;
		addr_in = 8'h00;
		wdata_in = 32'h0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		error_cnt = 0;
		total_checks = 0;
		cyc = 0;
		idx = 0;
		cnt = 0;
		expt[0] = 24'h000100;
		expt[1] = 24'h000300;
		expt[2] = 24'h000200;
		gn[0] = 16'h4000;
		gn[1] = 16'h9000;
		gn[2] = 16'h8000;
		rep[0] = 2'h2;
		rep[1] = 2'h1;
		rep[2] = 2'h1;
		repeat (10) @(posedge clock_in);
		rst_in <= 1'b0;
		idle(1);
		chk(horiz_cell_merge_out, 32'h1);
		rd(`CPS_A_COUNT);
		chk(got, 32'h1);
		rd(8'h1f);
		chk(got, 32'h0);
		wr(`CPS_A_COUNT, 32'h3);
		for (k = 0; k < 3; k = k + 1) begin
			wr(`CPS_A_EDIT_SEL, k);
			wr(`CPS_A_P_REPEAT, rep[k]);
			wr(`CPS_A_P_EXPTIME, expt[k]);
			wr(`CPS_A_P_EXPDELAY, expt[k] + 5);
			wr(`CPS_A_P_GAIN, gn[k]);
			wr(`CPS_A_P_LEFT, k * 16 + 3);
			wr(`CPS_A_P_HMERGE, k + 1);
			wr(`CPS_A_P_TOP, k * 8 + 1);
			wr(`CPS_A_P_VMERGE, k + 2);
		end
		wr(`CPS_A_P_HMERGE, 32'h0);
		rd(`CPS_A_P_HMERGE);
		chk(got, 32'h3);
		for (k = 0; k < 11; k = k + 1) begin
			if ((k < 3 || k > 5) && k != 9) begin
				wr(`CPS_A_FEAT_SEL, k);
				wr(`CPS_A_FEAT_EN, 32'h1);
			end
		end
		idle(2);
		chk(std_read_only_out, 32'h5c7);
		wr(`CPS_A_STD_WRITE, 32'h0);
		rd(`CPS_A_STATUS);
		chk(got & 32'h40, 32'h40);
		wr(`CPS_A_STD_WRITE, 32'h3);
		rd(`CPS_A_STATUS);
		chk(got & 32'h40, 32'h0);
		chk(max_exposure_out, 32'h300);
		wr(`CPS_A_CTRL, 32'h1);
		idle(2);
		chk_set;
		for (k = 0; k < 6; k = k + 1) begin
			adv;
			chk_set;
		end
		wr(`CPS_A_GAIN_SEL, 32'h1);
		idle(2);
		chk(analog_gain_out, 32'h9000);
		chk(digital_gain_out, 32'h0);
		wr(`CPS_A_GAIN_SEL, 32'h0);
		wr(`CPS_A_EVENT, 32'h2);
		idle(2);
		idx = 0;
		cnt = 0;
		chk(active_index_out, 32'h0);
		wr(`CPS_A_CTRL, 32'h3);
		idle(2);
		adv;
		adv;
		wr(`CPS_A_EVENT, 32'h2);
		idle(2);
		chk(active_index_out, 32'h1);
		rd(`CPS_A_STATUS);
		chk(got & 32'h20, 32'h20);
		wr(`CPS_A_EVENT, 32'h1);
		idle(3);
		chk(active_index_out, 32'h0);
		wr(`CPS_A_EDIT_SEL, 32'h0);
		for (k = 0; k < 3; k = k + 1) begin
			wr(`CPS_A_COLOR_SEL, k);
			wr(`CPS_A_P_COLOR, 32'h100 + k);
		end
		wr(`CPS_A_FEAT_SEL, `CPS_F_COLOR);
		wr(`CPS_A_FEAT_EN, 32'h1);
		idle(3);
		chk({red_gain_out, green_gain_out}, 32'h01000101);
		chk(blue_gain_out, 32'h102);
		wr(`CPS_A_CTRL, 32'h7);
		idle(4);
		chk({red_gain_out, green_gain_out | blue_gain_out}, 32'h0);
		wr(`CPS_A_P_COLOR, 32'h1ff);
		rd(`CPS_A_P_COLOR);
		chk(got, 32'h102);
		wr(`CPS_A_PIN_SEL, 32'h1);
		wr(`CPS_A_P_PIN, 32'h1);
		wr(`CPS_A_FEAT_SEL, `CPS_F_PIN_B);
		wr(`CPS_A_FEAT_EN, 32'h1);
		idle(3);
		chk(output_pin_ctrl_out, 32'h2);
		chk(output_pin_cycled_out, 32'h2);
		wr(`CPS_A_FEAT_SEL, `CPS_F_EXPTIME);
		wr(`CPS_A_FEAT_EN, 32'h0);
		idle(4);
		chk(std_read_only_out[0], 32'h0);
		chk(max_exposure_out, 32'h0);
		wr(`CPS_A_FEAT_SEL, `CPS_F_REPEAT);
		wr(`CPS_A_FEAT_EN, 32'h0);
		wr(`CPS_A_GLOBAL_CNT, 32'h2);
		wr(`CPS_A_EVENT, 32'h1);
		idle(1);
		chk(active_index_out, 32'h0);
		wr(`CPS_A_EVENT, 32'h1);
		idle(1);
		chk(active_index_out, 32'h1);
		end_sim;
	end
endmodule
